// >>> rtl/phy_regs_pkg.sv
// Shared constants and types for the basic control and status register block
package phy_regs_pkg;
  // ****************************************************************
  // Register addresses and field positions
  // ****************************************************************
  localparam logic [4:0]  REG_CONTROL      = 5'h00;
  localparam logic [4:0]  REG_STATUS       = 5'h01;
  localparam int          CTRL_RESET_BIT   = 15;
  localparam int          CTRL_LOOP_BIT    = 14;
  localparam int          CTRL_SPEED_BIT   = 13;
  localparam int          CTRL_PDOWN_BIT   = 11;
  localparam int          CTRL_ISO_BIT     = 10;
  localparam logic [9:0]  CTRL_RSVD_VALUE  = 10'h100;
  localparam int          STS_PRE_SUP_BIT  = 6;
  localparam int          STS_ANEG_OK_BIT  = 5;
  localparam int          STS_FAULT_BIT    = 4;
  localparam int          STS_LINK_BIT     = 2;
  localparam int          STS_JABBER_BIT   = 1;
  localparam int          STS_EXT_CAP_BIT  = 0;
  localparam logic [15:0] DATA_ZERO        = 16'h0000;
  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [4:0]  PCS_RESET_LOAD   = 5'h10;
  localparam logic [4:0]  PCS_RESET_IDLE   = 5'h00;
  localparam logic [5:0]  PREAMBLE_ONES    = 6'h20;
  localparam logic [3:0]  HDR_LAST         = 4'hc;
  localparam logic [4:0]  DATA_LAST        = 5'h0f;
  localparam logic [4:0]  SKIP_LAST        = 5'h11;
  // ****************************************************************
  // Management frame codes
  // ****************************************************************
  localparam logic [1:0]  OP_READ          = 2'h2;
  localparam logic [1:0]  OP_WRITE         = 2'h1;
  localparam logic [3:0]  NIBBLE_ZERO      = 4'h0;
  typedef enum logic [2:0] {
    MS_PREAMBLE,
    MS_HEADER,
    MS_TURN,
    MS_DATA,
    MS_SKIP
  } mgmt_state_t;
endpackage

// >>> rtl/reg_access_if.sv
// Register access strobes between the management frame logic and the bank
`timescale 1ns/1ps
interface reg_access_if;
  logic        rd_stb;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport link (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
  modport bank (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface

// >>> rtl/ctrl_status_bank.sv
// Control and status register bank with latched bits and soft reset
`timescale 1ns/1ps
module ctrl_status_bank (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  // Register access
  reg_access_if.bank acc,
  // Power-down pin and conditions from the line side
  input  wire logic  pdown_pin_n,
  input  wire logic  link_ok,
  input  wire logic  fault_evt,
  input  wire logic  jabber_evt,
  // Control outputs
  output logic       loopback,
  output logic       isolate,
  output logic       pdown_bit,
  output logic       pcs_reset
);
  import phy_regs_pkg::*;

  typedef struct packed {
    logic        loopback;
    logic        isolate;
    logic        pdown;
    logic [4:0]  reset_cnt;
    logic        fault;
    logic        jabber;
    logic        link;
    logic [15:0] rdata;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;
  logic        link_now;
  logic        rd_status;
  logic [15:0] ctrl_word;
  logic [15:0] sts_word;

  // Read views of both registers
  always_comb begin
    ctrl_word = {6'h00, CTRL_RSVD_VALUE};
    ctrl_word[CTRL_RESET_BIT] = (st_r.reset_cnt != PCS_RESET_IDLE);
    ctrl_word[CTRL_LOOP_BIT] = st_r.loopback;
    ctrl_word[CTRL_SPEED_BIT] = 1'b1;
    ctrl_word[CTRL_PDOWN_BIT] = st_r.pdown;
    ctrl_word[CTRL_ISO_BIT] = st_r.isolate;
    sts_word = DATA_ZERO;
    sts_word[STS_PRE_SUP_BIT] = 1'b1;
    sts_word[STS_ANEG_OK_BIT] = 1'b1;
    sts_word[STS_FAULT_BIT] = st_r.fault;
    sts_word[STS_LINK_BIT] = st_r.link;
    sts_word[STS_JABBER_BIT] = st_r.jabber;
    sts_word[STS_EXT_CAP_BIT] = 1'b1;
  end

  // Next state: latches, soft reset, writes
  always_comb begin
    st_nxt = st_r;
    link_now = link_ok & ~st_r.loopback;
    rd_status = acc.rd_stb && (acc.addr == REG_STATUS);
    if (acc.rd_stb) begin
      if (acc.addr == REG_CONTROL) begin
        st_nxt.rdata = ctrl_word;
      end else if (acc.addr == REG_STATUS) begin
        st_nxt.rdata = sts_word;
      end else begin
        st_nxt.rdata = DATA_ZERO;
      end
    end
    // Read re-arms, a new event still sets
    st_nxt.fault = (st_r.fault & ~rd_status) | fault_evt;
    st_nxt.jabber = (st_r.jabber & ~rd_status) | jabber_evt;
    st_nxt.link = rd_status ? link_now : (st_r.link & link_now);
    if (st_r.reset_cnt != PCS_RESET_IDLE) begin
      st_nxt.reset_cnt = 5'(st_r.reset_cnt - 5'h01);
    end
    if (acc.wr_stb && (acc.addr == REG_CONTROL)) begin
      if (acc.wdata[CTRL_RESET_BIT]) begin
        // Control bits and status latches return to defaults, reset count loaded
        st_nxt.reset_cnt = PCS_RESET_LOAD;
        st_nxt.loopback = 1'b0;
        st_nxt.isolate = 1'b0;
        st_nxt.pdown = 1'b0;
        st_nxt.fault = fault_evt;
        st_nxt.jabber = jabber_evt;
        st_nxt.link = 1'b0;
      end else begin
        st_nxt.loopback = acc.wdata[CTRL_LOOP_BIT];
        st_nxt.pdown = acc.wdata[CTRL_PDOWN_BIT];
        st_nxt.isolate = acc.wdata[CTRL_ISO_BIT];
      end
    end
    if (!pdown_pin_n) begin
      st_nxt.pdown = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign acc.rdata = st_r.rdata;
  assign loopback  = st_r.loopback;
  assign isolate   = st_r.isolate;
  assign pdown_bit = st_r.pdown;
  assign pcs_reset = (st_r.reset_cnt != PCS_RESET_IDLE);
endmodule

// >>> rtl/phy_basic_control_status_regs.sv
// Top of the basic control and status registers with management frame slave
// Summary of operation
// - Writing one to control bit 15 resets sublayer; reads one until done.
// - Soft reset leaves vendor-specific contents untouched.
// - Control bit 14 loops MAC transmit data back to MAC receive lines.
// - No link indication while MAC-side loopback is on.
// - Control bit 13 always reads one; writes ignored.
// - Control bit 11 powers down everything except register access.
// - Power down is bit 11 OR low pin; low pin also sets bit 11.
// - Control bit 10 isolates MAC-side data, management stays alive.
// - Status bits 15 to 11 always read zero.
// - Status bit 6 reads one; host sends 32 ones after reset or errors.
// - Status bit 5 always reads one.
// - Status bit 3 always reads zero.
// - Status bit 4 latches high on fault until read or reset.
// - Status bit 2 shows link, latched low, zero after reset.
// - Status bit 1 latches high on jabber.
// - Status bit 0 always reads one.
// - Latched-low bit holds zero until read, then follows condition.
// - Addresses 0x0 to 0x1F reached by direct frame access.
`timescale 1ns/1ps
module phy_basic_control_status_regs (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Serial management interface pins
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  // Address strap
  input  wire logic [4:0] phy_addr_strap,
  // Power-down pin
  input  wire logic       interrupt_powerdown_pin_n,
  // Line conditions
  input  wire logic       link_ok,
  input  wire logic       far_end_fault,
  input  wire logic       remote_fault_rx,
  input  wire logic       jabber_seen,
  // MAC side interface
  input  wire logic [3:0] mac_txd,
  input  wire logic       mac_tx_en,
  output logic [3:0]      mac_rxd,
  output logic            mac_rx_dv,
  output logic            mac_out_oe,
  // Line datapath
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_rx_dv,
  output logic [3:0]      line_txd,
  output logic            line_tx_en,
  // Device status
  output logic            link_indication,
  output logic            power_down,
  output logic            coding_sublayer_reset
);
  import phy_regs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    mgmt_state_t state;
    logic        mdc_prev;
    logic [5:0]  ones;
    logic        suppress_ok;
    logic [3:0]  hdr_cnt;
    logic [11:0] hdr;
    logic [4:0]  bit_cnt;
    logic [15:0] shift;
    logic        is_read;
    logic        oe;
    logic        out;
    logic [4:0]  phy_addr;
    logic        addr_taken;
    logic        rd_stb;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [3:0]  rxd;
    logic        rx_dv;
    logic [3:0]  txd;
    logic        tx_en;
    logic        mac_oe;
    logic        link_ind;
  } top_state_t;

  top_state_t   st_r;
  top_state_t   st_nxt;
  reg_access_if acc ();
  logic         loopback;
  logic         isolate;
  logic         pdown_bit;
  logic         pcs_reset;
  logic         pdown_eff;
  logic         quiet;
  logic         rise;
  logic [12:0]  hdr_full;

  // ****************************************************************
  // Register bank
  // ****************************************************************
  ctrl_status_bank u_bank (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .acc         (acc.bank),
    .pdown_pin_n (interrupt_powerdown_pin_n),
    .link_ok     (link_ok),
    .fault_evt   (far_end_fault | remote_fault_rx),
    .jabber_evt  (jabber_seen),
    .loopback    (loopback),
    .isolate     (isolate),
    .pdown_bit   (pdown_bit),
    .pcs_reset   (pcs_reset)
  );

  // Access strobes come straight from flops
  assign acc.rd_stb = st_r.rd_stb;
  assign acc.wr_stb = st_r.wr_stb;
  assign acc.addr   = st_r.addr;
  assign acc.wdata  = st_r.wdata;

  // Effective power down and quiet data path
  assign pdown_eff = pdown_bit | ~interrupt_powerdown_pin_n;
  assign quiet     = pdown_eff | isolate | pcs_reset;
  assign rise      = mdc & ~st_r.mdc_prev & st_r.addr_taken; // No false edge after reset
  assign hdr_full  = {st_r.hdr, mdio_in};

  // ****************************************************************
  // Management frame slave
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.mdc_prev = mdc;
    st_nxt.rd_stb = 1'b0;
    st_nxt.wr_stb = 1'b0;
    // Strap caught once after reset release
    if (!st_r.addr_taken) begin
      st_nxt.phy_addr = phy_addr_strap;
      st_nxt.addr_taken = 1'b1;
    end
    if (rise) begin
      case (st_r.state)
        // Count preamble ones, start bit zero opens a frame
        MS_PREAMBLE: begin
          if (mdio_in) begin
            if (st_r.ones != PREAMBLE_ONES) begin
              st_nxt.ones = 6'(st_r.ones + 6'h01);
            end
            if (6'(st_r.ones + 6'h01) == PREAMBLE_ONES) begin
              st_nxt.suppress_ok = 1'b1;
            end
          end else begin
            st_nxt.ones = 6'h00;
            if (st_r.suppress_ok) begin
              st_nxt.state = MS_HEADER;
              st_nxt.hdr_cnt = 4'h0;
              st_nxt.hdr = 12'h000;
            end
          end
        end
        // Second start bit, opcode, PHY address, register address
        MS_HEADER: begin
          st_nxt.hdr = hdr_full[11:0];
          st_nxt.hdr_cnt = 4'(st_r.hdr_cnt + 4'h1);
          if (st_r.hdr_cnt == HDR_LAST) begin
            st_nxt.addr = hdr_full[4:0];
            st_nxt.bit_cnt = 5'h00;
            if (!hdr_full[12] ||
                ((hdr_full[11:10] != OP_READ) && (hdr_full[11:10] != OP_WRITE))) begin
              st_nxt.suppress_ok = 1'b0;
              st_nxt.state = MS_PREAMBLE;
            end else if (hdr_full[9:5] != st_r.phy_addr) begin
              st_nxt.state = MS_SKIP;
            end else begin
              st_nxt.is_read = (hdr_full[11:10] == OP_READ);
              st_nxt.rd_stb = (hdr_full[11:10] == OP_READ);
              st_nxt.state = MS_TURN;
            end
          end
        end
        // Turnaround: drive zero then first data bit on reads
        MS_TURN: begin
          st_nxt.bit_cnt = 5'(st_r.bit_cnt + 5'h01);
          if (st_r.is_read) begin
            st_nxt.oe = 1'b1;
            if (st_r.bit_cnt == 5'h00) begin
              st_nxt.out = 1'b0;
            end else begin
              st_nxt.out = acc.rdata[15];
              st_nxt.shift = {acc.rdata[14:0], 1'b0};
              st_nxt.bit_cnt = 5'h00;
              st_nxt.state = MS_DATA;
            end
          end else if (st_r.bit_cnt == 5'h00) begin
            if (!mdio_in) begin
              st_nxt.suppress_ok = 1'b0;
              st_nxt.state = MS_PREAMBLE;
            end
          end else if (mdio_in) begin
            st_nxt.suppress_ok = 1'b0;
            st_nxt.state = MS_PREAMBLE;
          end else begin
            st_nxt.bit_cnt = 5'h00;
            st_nxt.state = MS_DATA;
          end
        end
        // Sixteen data bits out or in
        MS_DATA: begin
          st_nxt.bit_cnt = 5'(st_r.bit_cnt + 5'h01);
          if (st_r.is_read) begin
            if (st_r.bit_cnt == DATA_LAST) begin
              st_nxt.oe = 1'b0;
              st_nxt.out = 1'b0;
              st_nxt.state = MS_PREAMBLE;
            end else begin
              st_nxt.out = st_r.shift[15];
              st_nxt.shift = {st_r.shift[14:0], 1'b0};
            end
          end else begin
            st_nxt.shift = {st_r.shift[14:0], mdio_in};
            if (st_r.bit_cnt == DATA_LAST) begin
              st_nxt.wdata = {st_r.shift[14:0], mdio_in};
              st_nxt.wr_stb = 1'b1;
              st_nxt.state = MS_PREAMBLE;
            end
          end
        end
        // Frame for another address: let it pass
        MS_SKIP: begin
          st_nxt.bit_cnt = 5'(st_r.bit_cnt + 5'h01);
          if (st_r.bit_cnt == SKIP_LAST) begin
            st_nxt.state = MS_PREAMBLE;
          end
        end
        default: begin
          st_nxt.state = MS_PREAMBLE;
          st_nxt.oe = 1'b0;
        end
      endcase
    end

    // ****************************************************************
    // MAC-side data path
    // ****************************************************************
    // Receive toward MAC: loopback or line, silenced when quiet
    if (quiet) begin
      st_nxt.rxd = NIBBLE_ZERO;
      st_nxt.rx_dv = 1'b0;
    end else if (loopback) begin
      st_nxt.rxd = mac_txd;
      st_nxt.rx_dv = mac_tx_en;
    end else begin
      st_nxt.rxd = line_rxd;
      st_nxt.rx_dv = line_rx_dv;
    end
    // Transmit toward line stops in loopback or when quiet
    if (quiet || loopback) begin
      st_nxt.txd = NIBBLE_ZERO;
      st_nxt.tx_en = 1'b0;
    end else begin
      st_nxt.txd = mac_txd;
      st_nxt.tx_en = mac_tx_en;
    end
    st_nxt.mac_oe = ~(isolate | pdown_eff);
    st_nxt.link_ind = link_ok & ~loopback & ~pdown_eff & ~pcs_reset;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign mdio_out              = st_r.out;
  assign mdio_oe               = st_r.oe;
  assign mac_rxd               = st_r.rxd;
  assign mac_rx_dv             = st_r.rx_dv;
  assign mac_out_oe            = st_r.mac_oe;
  assign line_txd              = st_r.txd;
  assign line_tx_en            = st_r.tx_en;
  assign link_indication       = st_r.link_ind;
  assign power_down            = pdown_eff;
  assign coding_sublayer_reset = pcs_reset;
endmodule

// >>> tb/phy_regs_asserts.sv
// Port-level checks of the basic control and status register block
`timescale 1ns/1ps
module phy_regs_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic interrupt_powerdown_pin_n,
  input wire logic link_ok,
  input wire logic mac_rx_dv,
  input wire logic mac_out_oe,
  input wire logic line_tx_en,
  input wire logic link_indication,
  input wire logic power_down,
  input wire logic coding_sublayer_reset
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [5:0] sr_cnt_r;
  logic [5:0] sr_cnt_nxt;
  // Cycles spent in the current soft reset
  always_comb begin
    sr_cnt_nxt = coding_sublayer_reset ? sr_cnt_r + 6'h01 : 6'h00;
  end
  always_ff @(posedge sys_clk) begin
    sr_cnt_r <= rst_n ? sr_cnt_nxt : 6'h00;
  end
  property p_pin_pdown;
    !interrupt_powerdown_pin_n |-> power_down ##1 power_down;
  endproperty
  a_pin_pdown: assert property (p_pin_pdown)
    else $error("pin low but no power down");
  property p_no_link;
    !link_ok |=> !link_indication;
  endproperty
  a_no_link: assert property (p_no_link)
    else $error("link shown without line link");
  property p_pd_quiet;
    power_down |=> !mac_out_oe && !line_tx_en && !link_indication;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("activity during power down");
  property p_sr_len;
    $fell(coding_sublayer_reset) && $past(rst_n) |-> sr_cnt_r == 6'h10;
  endproperty
  a_sr_len: assert property (p_sr_len)
    else $error("soft reset length wrong");
  property p_sr_nolink;
    coding_sublayer_reset |=> !link_indication;
  endproperty
  a_sr_nolink: assert property (p_sr_nolink)
    else $error("link shown during soft reset");
  property p_ta_zero;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  a_ta_zero: assert property (p_ta_zero)
    else $error("turnaround not driven low");
  property p_iso_rx;
    !mac_out_oe |-> !mac_rx_dv;
  endproperty
  a_iso_rx: assert property (p_iso_rx)
    else $error("receive valid while isolated");
  property p_out_step;
    mdio_oe && $past(mdio_oe) && (mdio_out != $past(mdio_out)) |-> $past(mdc) && !$past(mdc, 2);
  endproperty
  a_out_step: assert property (p_out_step)
    else $error("read data changed off the mdc rise");
endmodule
bind phy_basic_control_status_regs phy_regs_asserts u_phy_regs_asserts (
  .sys_clk, .rst_n, .mdc, .mdio_out, .mdio_oe, .interrupt_powerdown_pin_n, .link_ok,
  .mac_rx_dv, .mac_out_oe, .line_tx_en, .link_indication, .power_down, .coding_sublayer_reset
);

// >>> tb/mgmt_host.sv
// Station management host model driving mdc and the shared data line
`timescale 1ns/1ps
module mgmt_host (
  // Clock
  input  wire logic sys_clk,
  // Management pins
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_in
);
  logic host_bit;
  logic host_en;
  // Shared line, pulled up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (host_en ? host_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    host_bit = 1'b1;
    host_en = 1'b0;
  end
  // One mdc period of six clocks, line sampled at the rise
  task automatic clk_bit(input logic b, input logic en, output logic smp);
    @(negedge sys_clk);
    host_bit = b;
    host_en = en;
    mdc = 1'b0;
    repeat (2) @(negedge sys_clk);
    smp = mdio_in;
    mdc = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask
  // Whole frame; host releases the line for read turnaround and data
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [1:0] ta,
                       input logic [15:0] wd, output logic [15:0] rdata);
    logic [13:0] hdr;
    logic        wr;
    logic        s;
    hdr = {2'b01, op, phy, ra};
    wr = (op != 2'b10);
    if (pre) begin
      for (int i = 0; i < 32; i++) clk_bit(1'b1, 1'b1, s);
    end
    for (int i = 13; i >= 0; i--) clk_bit(hdr[i], 1'b1, s);
    for (int i = 1; i >= 0; i--) clk_bit(ta[i], wr, s);
    for (int i = 15; i >= 0; i--) begin
      clk_bit(wd[i], wr, s);
      rdata[i] = s;
    end
    host_en = 1'b0;
  endtask
endmodule

// >>> tb/phy_basic_control_status_regs_test.sv
// Self-checking bench of the basic control and status register block
`timescale 1ns/1ps
module phy_basic_control_status_regs_test;
  import phy_regs_pkg::*;
  localparam logic [4:0] PHY = 5'h03;
  logic       sys_clk, rst_n, mdc, mdio_in, mdio_out, mdio_oe, pin_n;
  logic       link_ok, far_end_fault, remote_fault_rx, jabber_seen, mac_tx_en, line_rx_dv;
  logic       mac_rx_dv, mac_out_oe, line_tx_en, link_indication, power_down, csr;
  logic [3:0] mac_txd, mac_rxd, line_txd, line_rxd;
  int         fails, n_tests;
  // ********
  // Clock, device and host
  // ********
  always #25 sys_clk = ~sys_clk;
  phy_basic_control_status_regs u_phy_basic_control_status_regs (
    .sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr_strap(PHY), .interrupt_powerdown_pin_n(pin_n),
    .link_ok(link_ok), .far_end_fault(far_end_fault), .remote_fault_rx(remote_fault_rx),
    .jabber_seen(jabber_seen), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .mac_rxd(mac_rxd),
    .mac_rx_dv(mac_rx_dv), .mac_out_oe(mac_out_oe), .line_rxd(line_rxd),
    .line_rx_dv(line_rx_dv), .line_txd(line_txd), .line_tx_en(line_tx_en),
    .link_indication(link_indication),
    .power_down(power_down), .coding_sublayer_reset(csr));
  mgmt_host u_mgmt_host (.sys_clk(sys_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdc(mdc), .mdio_in(mdio_in));
  // ********
  // Shared tasks
  // ********
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input string what, input logic pre, input logic [4:0] a,
                       input logic [15:0] exp);
    logic [15:0] d;
    u_mgmt_host.frame(pre, OP_READ, PHY, a, 2'b11, DATA_ZERO, d);
    check(what, d, exp);
  endtask
  task automatic wr(input logic [15:0] v);
    logic [15:0] d;
    u_mgmt_host.frame(1'b0, OP_WRITE, PHY, REG_CONTROL, 2'b10, v, d);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic pulse(input logic [3:0] which);
    @(negedge sys_clk);
    {far_end_fault, jabber_seen, remote_fault_rx, link_ok} = which;
    @(negedge sys_clk);
    {far_end_fault, jabber_seen, remote_fault_rx, link_ok} = 4'h1;
  endtask
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset_values;
    rdchk("control at reset", 1'b1, REG_CONTROL, 16'h2100);
    rdchk("status at reset", 1'b0, REG_STATUS, 16'h0061);
    rdchk("unmapped reg", 1'b0, 5'h05, DATA_ZERO);
    rdchk("last direct reg", 1'b0, 5'h1f, DATA_ZERO);
  endtask
  task automatic t_latch;
    link_ok = 1'b1;
    rdchk("link held low", 1'b0, REG_STATUS, 16'h0061);
    rdchk("link present", 1'b0, REG_STATUS, 16'h0065);
    pulse(4'h0);
    rdchk("link drop held", 1'b0, REG_STATUS, 16'h0061);
    rdchk("link re-armed", 1'b0, REG_STATUS, 16'h0065);
    pulse(4'hd);
    rdchk("fault and jabber", 1'b0, REG_STATUS, 16'h0077);
    rdchk("latches cleared", 1'b0, REG_STATUS, 16'h0065);
    pulse(4'h3);
    rdchk("remote fault", 1'b0, REG_STATUS, 16'h0075);
  endtask
  task automatic t_control;
    wr(16'h4000);
    rdchk("loopback set", 1'b0, REG_CONTROL, 16'h6100);
    check("no link in loopback", {15'h0, link_indication}, DATA_ZERO);
    mac_txd = 4'ha;
    mac_tx_en = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("loopback data", {11'h0, mac_rx_dv, mac_rxd}, 16'h001a);
    check("line quiet in loopback", {11'h0, line_tx_en, line_txd}, DATA_ZERO);
    wr(16'h0400);
    rdchk("isolate readback", 1'b0, REG_CONTROL, 16'h2500);
    check("isolated mac", {15'h0, mac_out_oe}, DATA_ZERO);
    wr(16'h1fff);
    rdchk("fixed bits kept", 1'b0, REG_CONTROL, 16'h2d00);
    check("power down set", {15'h0, power_down}, 16'h0001);
    wr(DATA_ZERO);
    check("power down off", {15'h0, power_down}, DATA_ZERO);
    pin_n = 1'b0;
    @(negedge sys_clk);
    check("pin power down", {15'h0, power_down}, 16'h0001);
    wr(DATA_ZERO);
    rdchk("pin sets bit", 1'b0, REG_CONTROL, 16'h2900);
    pin_n = 1'b1;
    wr(DATA_ZERO);
    rdchk("back to normal", 1'b0, REG_CONTROL, 16'h2100);
    check("link shown again", {15'h0, link_indication}, 16'h0001);
    line_rxd = 4'h5;
    line_rx_dv = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("line to mac", {11'h0, mac_rx_dv, mac_rxd}, 16'h0015);
    check("mac to line", {11'h0, line_tx_en, line_txd}, 16'h001a);
  endtask
  task automatic t_soft_reset;
    logic [15:0] d;
    wr(16'h4000);
    u_mgmt_host.frame(1'b0, OP_WRITE, PHY, REG_CONTROL, 2'b10, 16'h8000, d);
    check("reset running", {15'h0, csr}, 16'h0001);
    for (int n = 0; n < 40 && csr === 1'b1; n++) @(negedge sys_clk);
    check("reset ended", {15'h0, csr}, DATA_ZERO);
    rdchk("control after reset", 1'b0, REG_CONTROL, 16'h2100);
    rdchk("status after reset", 1'b0, REG_STATUS, 16'h0061);
  endtask
  task automatic t_refuse;
    logic [15:0] d;
    u_mgmt_host.frame(1'b0, OP_READ, 5'h04, REG_CONTROL, 2'b11, DATA_ZERO, d);
    check("other phy address", d, 16'hffff);
    u_mgmt_host.frame(1'b0, 2'b00, PHY, REG_CONTROL, 2'b10, DATA_ZERO, d);
    rdchk("after bad opcode", 1'b0, REG_CONTROL, 16'hffff);
    rdchk("with preamble", 1'b1, REG_CONTROL, 16'h2100);
    u_mgmt_host.frame(1'b0, OP_WRITE, PHY, REG_CONTROL, 2'b11, 16'h4000, d);
    rdchk("bad turnaround write", 1'b1, REG_CONTROL, 16'h2100);
  endtask
  task automatic t_hw_reset;
    pulse(4'hd);
    rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    rdchk("frame needs preamble", 1'b0, REG_STATUS, 16'hffff);
    rdchk("status after hw reset", 1'b1, REG_STATUS, 16'h0061);
  endtask
  // ********
  // Main sequence and watchdog
  // ********
  initial begin
    {sys_clk, rst_n, far_end_fault, remote_fault_rx, jabber_seen, link_ok} = 6'h00;
    {mac_txd, mac_tx_en, pin_n, line_rxd, line_rx_dv, fails, n_tests} = 0;
    pin_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_reset_values();
    t_latch();
    t_control();
    t_soft_reset();
    t_refuse();
    t_hw_reset();
    summarize();
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    summarize();
  end
endmodule
